// ===== watchdog_pkg.sv
package watchdog_pkg;

    // register byte offsets on the control bus
    localparam logic [7:0] CONTROL_OFFSET   = 8'h00;
    localparam logic [7:0] CONFIG_OFFSET    = 8'h04;
    localparam logic [7:0] STATE_OFFSET     = 8'h08;
    localparam logic [7:0] EVENT_OFFSET     = 8'h0c;
    localparam logic [7:0] EVENT_EN_OFFSET  = 8'h10;
    localparam logic [7:0] EVENT_CLR_OFFSET = 8'h14;
    localparam logic [7:0] COUNT_OFFSET     = 8'h18;

    // watchdog_control layout
    localparam int         SOFT_EN_BIT     = 0;
    localparam int         PERIOD_LSB      = 1;
    localparam int         PERIOD_W        = 5;
    localparam logic [4:0] PERIOD_RESET    = 5'h0b;
    localparam logic [4:0] PERIOD_MAX_CODE = 5'h12;
    localparam logic [4:0] PERIOD_MIN_CODE = 5'h00;
    localparam logic       SOFT_EN_RESET   = 1'b0;

    // mode field encodings
    typedef enum logic [1:0] {
        MODE_OFF      = 2'b00,
        MODE_SOFTWARE = 2'b01,
        MODE_AWAKE    = 2'b10,
        MODE_ALWAYS   = 2'b11
    } wdt_mode_t;

    // state register bits
    localparam int TIMEOUT_N_BIT   = 0;
    localparam int POWERDOWN_N_BIT = 1;
    localparam int ACTIVE_BIT      = 2;

    // event register bits
    localparam int EVENT_W        = 2;
    localparam int EV_RESET_BIT   = 0;
    localparam int EV_WAKE_BIT    = 1;

    // time base: prescale 1:32 of the low-frequency oscillator
    localparam int LFO_FREQ_HZ     = 31000;
    localparam int CLK_FREQ_HZ     = 25000000;
    localparam int BASE_SHIFT      = 5;
    localparam int COUNT_W         = 23;

    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage : watchdog_pkg

// ===== watchdog_timer_sleep_aware.sv
// The AXI4-Lite interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
module watchdog_timer_sleep_aware
    import watchdog_pkg::*;
#(
    parameter int        ADDR_W     = 8,
    parameter wdt_mode_t MODE_RESET = MODE_ALWAYS
) (
    input  wire logic              clk,
    input  wire logic              reset_n,
    input  wire logic              lowFreqInternalOsc,
    input  wire logic              watchdogClearInstr,
    input  wire logic              sleepActive,
    input  wire logic              oscFailDetected,
    input  wire logic              oscStartupTimerRunning,
    input  wire logic              crystalClockSource,
    output logic                   deviceReset,
    output logic                   wakeUp,
    output logic                   timeoutStatusN,
    output logic                   powerdownStatusN,
    output logic                   irq,
    input  wire logic [ADDR_W-1:0] awaddr,
    input  wire logic              awvalid,
    output logic                   awready,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    input  wire logic [ADDR_W-1:0] araddr,
    input  wire logic              arvalid,
    output logic                   arready,
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready
);

    // the oscillator must be sampled well below half the clock rate
    if (ADDR_W < 5 || LFO_FREQ_HZ * 4 > CLK_FREQ_HZ) begin : g_check
        $error("watchdog: address too narrow or oscillator too fast");
    end

    logic [2:0]          lfoSync_q;
    logic                lfoTick;
    logic [COUNT_W-1:0]  count_q;
    logic [COUNT_W-1:0]  countLast;
    logic [4:0]          period_q;
    logic                softEn_q;
    wdt_mode_t           mode_q;
    logic                sleep_q;
    logic                sleepEntry;
    logic                sleepExit;
    logic                active;
    logic                countClear;
    logic                timeoutHit;
    logic [EVENT_W-1:0]  event_q;
    logic [EVENT_W-1:0]  eventEn_q;
    logic [EVENT_W-1:0]  eventClr;
    logic                awHeld_q;
    logic                wHeld_q;
    logic [ADDR_W-1:0]   awAddr_q;
    logic [31:0]         wData_q;
    logic [3:0]          wStrb_q;
    logic                doWrite;
    logic                writeHit;
    logic [31:0]         readWord;
    logic                readHit;

    ////////////////////////////////////////////////////////////////////////////
    // time base

    // three stages; only the later two are compared, first is metastable
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            lfoSync_q <= 3'h0;
        end else begin
            lfoSync_q <= {lfoSync_q[1:0], lowFreqInternalOsc};
        end
    end

    // one tick per rising oscillator edge, independent of clk rate
    assign lfoTick = lfoSync_q[1] & ~lfoSync_q[2];

    // last count before time-out; reserved codes fall back to 1:32
    always_comb begin
        if (period_q > PERIOD_MAX_CODE) begin
            countLast = (COUNT_W'(1) << BASE_SHIFT) - COUNT_W'(1);
        end else begin
            countLast = (COUNT_W'(1) << (BASE_SHIFT + int'(period_q))) - COUNT_W'(1);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // mode and clearing

    assign sleepEntry = sleepActive & ~sleep_q;
    assign sleepExit  = ~sleepActive & sleep_q;

    // operating mode table
    always_comb begin
        case (mode_q)
            MODE_ALWAYS:   active = 1'b1;
            MODE_AWAKE:    active = ~sleepActive;
            MODE_SOFTWARE: active = softEn_q;
            MODE_OFF:      active = 1'b0;
            default:       active = 1'b0;
        endcase
    end

    // divider setting of the fast oscillator is not an input at all
    assign countClear = watchdogClearInstr | sleepEntry | sleepExit
                      | oscFailDetected | ~active
                      | (crystalClockSource & oscStartupTimerRunning);

    assign timeoutHit = active & ~countClear & lfoTick & (count_q == countLast);

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            sleep_q <= 1'b0;
        end else begin
            sleep_q <= sleepActive;
        end
    end

    // counter restarts from zero after a time-out too
    always_ff @(posedge clk) begin
        if (!reset_n || countClear || timeoutHit) begin
            count_q <= '0;
        end else if (lfoTick) begin
            count_q <= count_q + COUNT_W'(1);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // time-out outcome and power status

    // reset when awake, wake-up pulse when asleep
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            deviceReset <= 1'b0;
            wakeUp      <= 1'b0;
        end else begin
            deviceReset <= timeoutHit & ~sleepActive;
            wakeUp      <= timeoutHit & sleepActive;
        end
    end

    // flags are active low; a same-cycle clear suppresses the time-out
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            timeoutStatusN   <= 1'b1;
            powerdownStatusN <= 1'b1;
        end else if (timeoutHit) begin
            timeoutStatusN   <= 1'b0;
        end else if (sleepEntry) begin
            timeoutStatusN   <= 1'b1;
            powerdownStatusN <= 1'b0;
        end else if (watchdogClearInstr) begin
            timeoutStatusN   <= 1'b1;
            powerdownStatusN <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt events

    // set wins over a clear written in the same cycle
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            event_q <= '0;
        end else begin
            event_q <= (event_q & ~eventClr)
                     | {timeoutHit & sleepActive, timeoutHit & ~sleepActive};
        end
    end

    assign irq = |(event_q & eventEn_q);

    ////////////////////////////////////////////////////////////////////////////
    // bus write side

    assign awready  = ~awHeld_q;
    assign wready   = ~wHeld_q;
    assign doWrite  = awHeld_q & wHeld_q & ~bvalid;
    assign eventClr = (doWrite && awAddr_q == EVENT_CLR_OFFSET && wStrb_q[0])
                    ? wData_q[EVENT_W-1:0] : '0;

    // address and data held independently until both have arrived
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            awHeld_q <= 1'b0;
            wHeld_q  <= 1'b0;
            awAddr_q <= '0;
            wData_q  <= '0;
            wStrb_q  <= '0;
        end else begin
            if (awvalid && awready) begin
                awHeld_q <= 1'b1;
                awAddr_q <= awaddr;
            end else if (doWrite) begin
                awHeld_q <= 1'b0;
            end
            if (wvalid && wready) begin
                wHeld_q <= 1'b1;
                wData_q <= wdata;
                wStrb_q <= wstrb;
            end else if (doWrite) begin
                wHeld_q <= 1'b0;
            end
        end
    end

    always_comb begin
        case (awAddr_q)
            CONTROL_OFFSET, CONFIG_OFFSET, EVENT_EN_OFFSET,
            EVENT_CLR_OFFSET: writeHit = 1'b1;
            default:          writeHit = 1'b0;
        endcase
    end

    // response one cycle after both halves are held
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            bvalid <= 1'b0;
            bresp  <= RESP_OKAY;
        end else if (doWrite) begin
            bvalid <= 1'b1;
            bresp  <= writeHit ? RESP_OKAY : RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // control registers sit in byte lane 0
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            period_q  <= PERIOD_RESET;
            softEn_q  <= SOFT_EN_RESET;
            mode_q    <= MODE_RESET;
            eventEn_q <= '0;
        end else if (doWrite && wStrb_q[0]) begin
            case (awAddr_q)
                CONTROL_OFFSET: begin
                    period_q <= wData_q[PERIOD_LSB +: PERIOD_W];
                    softEn_q <= wData_q[SOFT_EN_BIT];
                end
                CONFIG_OFFSET:   mode_q    <= wdt_mode_t'(wData_q[1:0]);
                EVENT_EN_OFFSET: eventEn_q <= wData_q[EVENT_W-1:0];
                default:         ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // bus read side

    assign arready = ~rvalid;

    // unused bits read as zero; clear register reads zero
    always_comb begin
        readWord = 32'h0;
        readHit  = 1'b1;
        case (araddr)
            CONTROL_OFFSET: begin
                readWord[PERIOD_LSB +: PERIOD_W] = period_q;
                readWord[SOFT_EN_BIT]            = softEn_q;
            end
            CONFIG_OFFSET:    readWord[1:0] = mode_q;
            STATE_OFFSET: begin
                readWord[TIMEOUT_N_BIT]   = timeoutStatusN;
                readWord[POWERDOWN_N_BIT] = powerdownStatusN;
                readWord[ACTIVE_BIT]      = active;
            end
            EVENT_OFFSET:     readWord[EVENT_W-1:0] = event_q;
            EVENT_EN_OFFSET:  readWord[EVENT_W-1:0] = eventEn_q;
            EVENT_CLR_OFFSET: readWord = 32'h0;
            COUNT_OFFSET:     readWord[COUNT_W-1:0] = count_q;
            default:          readHit = 1'b0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            rvalid <= 1'b0;
            rdata  <= 32'h0;
            rresp  <= RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rdata  <= readWord;
            rresp  <= readHit ? RESP_OKAY : RESP_SLVERR;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks

    always_on_a: assert property (@(posedge clk) disable iff (!reset_n)
        mode_q == MODE_ALWAYS |-> active)
        else $error("always-on mode not active");
    mode_off_a: assert property (@(posedge clk) disable iff (!reset_n)
        mode_q == MODE_OFF |=> count_q == '0 && !deviceReset)
        else $error("off mode still counting");
    sleep_off_a: assert property (@(posedge clk) disable iff (!reset_n)
        mode_q == MODE_AWAKE |-> active == !sleepActive)
        else $error("awake-only mode wrong");
    soft_mode_a: assert property (@(posedge clk) disable iff (!reset_n)
        mode_q == MODE_SOFTWARE && !softEn_q |=> count_q == '0)
        else $error("software-disabled watchdog counting");
    clear_instr_a: assert property (@(posedge clk) disable iff (!reset_n)
        watchdogClearInstr |=> count_q == '0 ##1 !deviceReset)
        else $error("clear instruction ignored");
    sleep_entry_a: assert property (@(posedge clk) disable iff (!reset_n)
        sleepEntry |=> count_q == '0 && !powerdownStatusN && timeoutStatusN)
        else $error("sleep entry handling wrong");
    startup_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
        crystalClockSource && oscStartupTimerRunning |=> count_q == '0)
        else $error("count moved during start-up timer");
    awake_reset_a: assert property (@(posedge clk) disable iff (!reset_n)
        timeoutHit && !sleepActive |=> deviceReset && !wakeUp ##1 !deviceReset)
        else $error("awake time-out gave no reset pulse");
    sleep_wake_a: assert property (@(posedge clk) disable iff (!reset_n)
        timeoutHit && sleepActive |=> wakeUp && !deviceReset && !timeoutStatusN)
        else $error("sleep time-out not a wake-up");
    tick_only_a: assert property (@(posedge clk) disable iff (!reset_n)
        count_q != $past(count_q) && count_q != '0 |-> $past(lfoTick))
        else $error("count advanced without oscillator tick");
    reset_period_a: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(reset_n) |-> period_q == PERIOD_RESET)
        else $error("period not at reset value");
    // reserved codes must expire on the lowest prescale bits only
    reserved_code_a: assert property (@(posedge clk) disable iff (!reset_n)
        timeoutHit && period_q > PERIOD_MAX_CODE |-> !(|count_q[COUNT_W-1:BASE_SHIFT])
            && (&count_q[BASE_SHIFT-1:0]))
        else $error("reserved period not minimum");
    enable_start_a: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(active) |-> count_q == '0)
        else $error("enable did not start from zero");

    awake_timeout_c: cover property (@(posedge clk) disable iff (!reset_n)
        timeoutHit && !sleepActive);
    sleep_timeout_c: cover property (@(posedge clk) disable iff (!reset_n)
        timeoutHit && sleepActive);
    irq_raise_c: cover property (@(posedge clk) disable iff (!reset_n)
        $rose(irq));

endmodule : watchdog_timer_sleep_aware

// ===== watchdog_timer_sleep_aware_tb.sv
`timescale 1ns/10ps
module watchdog_timer_sleep_aware_tb;
    import watchdog_pkg::*;

    logic        clk;
    logic        reset_n;
    logic        lowFreqInternalOsc;
    logic        watchdogClearInstr;
    logic        sleepActive;
    logic        oscFailDetected;
    logic        oscStartupTimerRunning;
    logic        crystalClockSource;
    logic        deviceReset;
    logic        wakeUp;
    logic        timeoutStatusN;
    logic        powerdownStatusN;
    logic        irq;
    logic [7:0]  awaddr;
    logic        awvalid;
    logic        awready;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        bready;
    logic [7:0]  araddr;
    logic        arvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
    logic        rready;
    int          nMismatch;
    int          totalChecks;
    int          nRst;
    int          nWake;
    int          seed;

    watchdog_timer_sleep_aware #(.ADDR_W(8)) dut_u (.*);

    ////////////////////////////////////////////////////////////////
    // clock, pulse counters, watchdog
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // pulses are one cycle wide, so one count per high sample
    always @(posedge clk) begin
        if (deviceReset === 1'b1) nRst++;
        if (wakeUp === 1'b1) nWake++;
    end

    // whole sequence needs at most roughly 12k cycles
    initial begin
        repeat (60000) @(posedge clk);
        nMismatch++;
        stopTest();
    end

    ////////////////////////////////////////////////////////////////
    // helpers
    task automatic stopTest();
        if (nMismatch == 0 && totalChecks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : stopTest

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        totalChecks++;
        if (got !== exp) begin
            nMismatch++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // expected ticks to time-out for a period code
    function automatic int ticksFor(input logic [4:0] code);
        return (code > PERIOD_MAX_CODE) ? 32 : (32 << code);
    endfunction : ticksFor

    // oscillator tick: five clocks high, five low, beyond the synchroniser
    task automatic tick(input int n);
        repeat (n) begin
            lowFreqInternalOsc <= 1'b1;
            repeat (5) @(posedge clk);
            lowFreqInternalOsc <= 1'b0;
            repeat (5) @(posedge clk);
        end
    endtask : tick

    task automatic clr();
        watchdogClearInstr <= 1'b1;
        @(posedge clk);
        watchdogClearInstr <= 1'b0;
        repeat (2) @(posedge clk);
    endtask : clr

    // write: address and data offered together, each dropped when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] expResp);
        logic awOpen;
        logic wOpen;
        logic bSeen;
        awOpen  = 1'b1;
        wOpen   = 1'b1;
        bSeen   = 1'b0;
        awaddr  <= a;
        wdata   <= d;
        wstrb   <= 4'hf;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        // local flags, since the valids only change after this time step
        while (!bSeen) begin
            @(posedge clk);
            if (awOpen && awready) begin
                awOpen  = 1'b0;
                awvalid <= 1'b0;
            end
            if (wOpen && wready) begin
                wOpen  = 1'b0;
                wvalid <= 1'b0;
            end
            if (bvalid) begin
                bSeen  = 1'b1;
                bready <= 1'b0;
            end
        end
        chk({30'h0, bresp}, {30'h0, expResp});
        // idle edge so the next call never reassigns bready in this step
        @(posedge clk);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                      input logic [1:0] expResp);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do @(posedge clk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge clk); while (!rvalid);
        rready <= 1'b0;
        chk(rdata, exp);
        chk({30'h0, rresp}, {30'h0, expResp});
        // idle edge so the next call never reassigns rready in this step
        @(posedge clk);
    endtask : rd

    ////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        logic [4:0] code;
        int         n;
        int         base;
        seed = 32'hd2589e32;
        {reset_n, lowFreqInternalOsc, watchdogClearInstr, sleepActive} = 4'h0;
        {oscFailDetected, oscStartupTimerRunning, crystalClockSource} = 3'h0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata  = 32'h0;
        wstrb  = 4'h0;
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        // defaults after reset, and bus refusals
        rd(CONTROL_OFFSET, {26'h0, PERIOD_RESET, SOFT_EN_RESET}, RESP_OKAY);
        rd(CONFIG_OFFSET, 32'h3, RESP_OKAY);
        rd(STATE_OFFSET, 32'h7, RESP_OKAY);
        rd(EVENT_OFFSET, 32'h0, RESP_OKAY);
        rd(COUNT_OFFSET, 32'h0, RESP_OKAY);
        rd(8'h1c, 32'h0, RESP_SLVERR);
        wr(STATE_OFFSET, 32'h0, RESP_SLVERR);
        // awake time-out at exactly 32 ticks with period 0
        wr(CONTROL_OFFSET, 32'h0, RESP_OKAY);
        wr(EVENT_EN_OFFSET, 32'h1, RESP_OKAY);
        tick(31);
        chk(nRst, 0);
        tick(1);
        chk(nRst, 1);
        rd(STATE_OFFSET, 32'h6, RESP_OKAY);
        rd(EVENT_OFFSET, 32'h1, RESP_OKAY);
        chk({31'h0, irq}, 32'h1);
        wr(EVENT_EN_OFFSET, 32'h0, RESP_OKAY);
        chk({31'h0, irq}, 32'h0);
        wr(EVENT_CLR_OFFSET, 32'h1, RESP_OKAY);
        rd(EVENT_OFFSET, 32'h0, RESP_OKAY);
        clr();
        rd(STATE_OFFSET, 32'h7, RESP_OKAY);
        // mode off, then software mode with enable low and high
        wr(CONFIG_OFFSET, {30'h0, MODE_OFF}, RESP_OKAY);
        tick(40);
        rd(COUNT_OFFSET, 32'h0, RESP_OKAY);
        wr(CONFIG_OFFSET, {30'h0, MODE_SOFTWARE}, RESP_OKAY);
        tick(40);
        rd(COUNT_OFFSET, 32'h0, RESP_OKAY);
        rd(STATE_OFFSET, 32'h3, RESP_OKAY);
        wr(CONTROL_OFFSET, 32'h1, RESP_OKAY);
        tick(31);
        chk(nRst, 1);
        tick(1);
        chk(nRst, 2);
        // awake-only mode stops in sleep
        wr(CONFIG_OFFSET, {30'h0, MODE_AWAKE}, RESP_OKAY);
        tick(5);
        sleepActive <= 1'b1;
        tick(40);
        rd(COUNT_OFFSET, 32'h0, RESP_OKAY);
        chk(nWake, 0);
        sleepActive <= 1'b0;
        // always-on mode wakes instead of resetting
        wr(CONFIG_OFFSET, {30'h0, MODE_ALWAYS}, RESP_OKAY);
        tick(10);
        sleepActive <= 1'b1;
        repeat (2) @(posedge clk);
        tick(31);
        chk(nWake, 0);
        tick(1);
        chk(nWake, 1);
        chk(nRst, 2);
        rd(STATE_OFFSET, 32'h4, RESP_OKAY);
        chk({30'h0, timeoutStatusN, powerdownStatusN}, 32'h0);
        sleepActive <= 1'b0;
        repeat (2) @(posedge clk);
        rd(COUNT_OFFSET, 32'h0, RESP_OKAY);
        // crystal source holds clear while start-up timer runs
        crystalClockSource     <= 1'b1;
        oscStartupTimerRunning <= 1'b1;
        tick(40);
        rd(COUNT_OFFSET, 32'h0, RESP_OKAY);
        oscStartupTimerRunning <= 1'b0;
        tick(31);
        chk(nRst, 2);
        tick(1);
        chk(nRst, 3);
        crystalClockSource <= 1'b0;
        oscFailDetected    <= 1'b1;
        tick(40);
        rd(COUNT_OFFSET, 32'h0, RESP_OKAY);
        oscFailDetected <= 1'b0;
        // random period codes, high reserved codes among them
        for (int i = 0; i < 6; i++) begin
            code = 5'($random(seed));
            if (code > 5'h02 && code <= PERIOD_MAX_CODE) code = code % 3;
            if (i == 0) code = 5'h13; // lowest reserved code, fixed corner
            n = 1 + (($random(seed) & 32'h7fff_ffff) % 20);
            wr(CONTROL_OFFSET, {26'h0, code, 1'($random(seed))}, RESP_OKAY);
            clr();
            tick(n);
            rd(COUNT_OFFSET, 32'(n), RESP_OKAY);
            clr();
            rd(COUNT_OFFSET, 32'h0, RESP_OKAY);
            base = nRst;
            tick(ticksFor(code) - 1);
            chk(nRst, base);
            tick(1);
            chk(nRst, base + 1);
        end
        // mid-run reset brings count and period back to defaults
        tick(3);
        reset_n <= 1'b0;
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        rd(COUNT_OFFSET, 32'h0, RESP_OKAY);
        rd(CONTROL_OFFSET, {26'h0, PERIOD_RESET, SOFT_EN_RESET}, RESP_OKAY);
        stopTest();
    end

endmodule : watchdog_timer_sleep_aware_tb
